// ==== pkg/pxn_regs.svh ====
// Constants of the packet exchange network: sizes, fields and rates.
// Assumes inclusion by bare name from the exchange design files.
`ifndef PXN_REGS_SVH
`define PXN_REGS_SVH

// Mesh shape
`define PXN_PORTS      4
`define PXN_LOCI       5
`define PXN_HUB_LOCUS  4
`define PXN_LINKS      20
`define PXN_SLOTS      4

// Word widths
`define PXN_WORD_W     36
`define PXN_HUB_W      64
`define PXN_PTR_W      9

// Side bits of the first and last packet word
`define PXN_TAG_MSB    35
`define PXN_TAG_LSB    32

// Pointer access word layout
`define PXN_RPTR_LSB   0
`define PXN_WPTR_LSB   16
`define PXN_OVF_BIT    32

// Clock rates in MHz: packet logic, hub system and this fabric clock
`define PXN_PORT_MHZ   62.5
`define PXN_HUB_MHZ    300
`define PXN_CLK_MHZ    40

// Pointer reset value
`define PXN_PTR_RST    9'h000

`endif

// ==== pkg/pxn_pkg.sv ====
// Types shared by the packet exchange network design files.
// Assumes pxn_regs.svh supplies the numeric constants.
package pxn_pkg;

   // Hub request kinds
   typedef enum logic [1:0] {
      PXN_OP_MEM_RD = 2'b00,
      PXN_OP_MEM_WR = 2'b01,
      PXN_OP_PTR_RD = 2'b10,
      PXN_OP_PTR_WR = 2'b11
   } pxn_op_t;

   // Hub request sequencer states
   typedef enum logic [1:0] {
      PXN_HUB_IDLE = 2'b00,
      PXN_HUB_EXEC = 2'b01,
      PXN_HUB_FIN  = 2'b10
   } pxn_hub_state_t;

endpackage

// ==== hdl/pxn_link_mem.sv ====
// One link buffer: simple dual-port memory, one write and one read port.
// Assumes a single clock; read data come out of a register.
`timescale 1ns/1ps
module pxn_link_mem #(
   parameter int AW = 9,
   parameter int DW = 36
) (
   input  wire logic          clk,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);

   // Storage array, one word per address
   logic [DW-1:0] mem_reg [1<<AW];

   // Write port, used only by the writing side
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   // Read port, used only by the reading side
   always_ff @(posedge clk) begin
      rd_data <= mem_reg[rd_addr];
   end

endmodule

// ==== hdl/pxn_exchange.sv ====
// Full-mesh packet exchange between four ports and the hub.
// Assumes port logic on clk, hub requests by toggle from another domain.
// Operation
// R01 - Twenty one-way links, five sources, four destinations
// R02 - Each link owns one dual-port buffer
// R03 - Each locus reads four buffers, one per writer
// R04 - Words and data paths are 36 bits
// R05 - Write to full buffer dropped, overflow flagged
// R06 - Only committed whole packets reach readers
// R07 - Readers pick non-empty buffers round robin
// R08 - Hub gets random access to its buffers
// R09 - Hub reads all pointers, writes own only
// R10 - Ports push and pop without addresses
// R11 - Port logic runs in packet clock domain
// R12 - Hub system runs in separate clock domain
// R13 - Edge words carry offset and byte mask
// R14 - Commit advances visible pointer, abort rolls back
// R15 - Cross-domain requests synchronised before use
`timescale 1ns/1ps
`include "pxn_regs.svh"
module pxn_exchange
   import pxn_pkg::*;
#(
   parameter int AW = `PXN_PTR_W
) (
   input  wire logic                              clk,
   input  wire logic                              reset_n,
   input  wire logic [`PXN_PORTS-1:0]             wr_valid,
   input  wire logic [`PXN_PORTS*`PXN_WORD_W-1:0] wr_data,
   input  wire logic [`PXN_PORTS*`PXN_SLOTS-1:0]  wr_dest,
   input  wire logic [`PXN_PORTS-1:0]             wr_commit,
   input  wire logic [`PXN_PORTS-1:0]             wr_abort,
   input  wire logic [`PXN_PORTS-1:0]             rd_pop,
   input  wire logic [`PXN_PORTS-1:0]             rd_done,
   output logic      [`PXN_PORTS-1:0]             rd_valid,
   output logic      [`PXN_PORTS*`PXN_WORD_W-1:0] rd_data,
   output logic      [`PXN_PORTS*2-1:0]           rd_slot,
   output logic      [`PXN_LINKS-1:0]             overflow,
   input  wire logic                              hub_req,
   input  wire pxn_op_t                           hub_op,
   input  wire logic [2:0]                        hub_sel,
   input  wire logic [4:0]                        hub_link,
   input  wire logic [AW-1:0]                     hub_addr,
   input  wire logic [`PXN_HUB_W-1:0]             hub_wdata,
   output logic      [`PXN_HUB_W-1:0]             hub_rdata,
   output logic                                   hub_ack
);

   // Per-link pointer state and memory wires
   logic [AW-1:0]          wptr_reg [`PXN_LINKS];  // Reader-visible end
   logic [AW-1:0]          rptr_reg [`PXN_LINKS];  // Read position
   logic [AW-1:0]          rptr_nx  [`PXN_LINKS];  // Read position next
   logic                   ovf_reg  [`PXN_LINKS];  // Sticky overflow
   logic [`PXN_WORD_W-1:0] mdata    [`PXN_LINKS];  // Memory read data

   // Hub request synchroniser and captured operands
   logic                   req_s1_reg;             // First sync stage
   logic                   req_s2_reg;             // Second sync stage
   logic                   req_s3_reg;             // Edge reference
   pxn_hub_state_t         hub_state_reg;          // Sequencer state
   pxn_op_t                op_reg;                 // Captured kind
   logic [2:0]             sel_reg;                // Captured buffer
   logic [4:0]             link_reg;               // Captured link
   logic [AW-1:0]          addr_reg;               // Captured address
   logic [`PXN_HUB_W-1:0]  wdata_reg;              // Captured data
   logic [`PXN_HUB_W-1:0]  hub_rdata_reg;          // Answer word
   logic                   hub_ack_reg;            // Answer toggle

   // Reader arbitration state per port
   logic                   lock_reg  [`PXN_PORTS]; // Packet in progress
   logic [1:0]             slot_reg  [`PXN_PORTS]; // Chosen receive slot
   logic                   valid_reg [`PXN_PORTS]; // Word at output

   // Decoded hub actions; the two writes are live during the execute state
   wire hub_go     = req_s2_reg ^ req_s3_reg;
   wire hub_exec   = hub_state_reg == PXN_HUB_EXEC;
   wire hub_mem_wr = hub_exec && op_reg == PXN_OP_MEM_WR;
   wire hub_ptr_wr = hub_exec && op_reg == PXN_OP_PTR_WR;
   wire link_ok    = link_reg < 5'(`PXN_LINKS);
   wire [4:0] hub_rd_link = {1'b0, sel_reg[1:0], 2'b11};

   // Round robin: first requesting slot after the last one served
   function automatic logic [2:0] rr_pick(input logic [3:0] req,
                                          input logic [1:0] last);
      logic [2:0] res;
      logic [1:0] idx;
      res = 3'h0;
      for (int i = 4; i >= 1; i--) begin
         idx = 2'(last + 2'(i));
         if (req[idx]) begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction

   // R12 R15 foreign hub toggle, two-stage sync
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
      end else begin
         req_s1_reg <= hub_req;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
      end
   end

   // Hub sequencer: capture, execute, answer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hub_state_reg <= PXN_HUB_IDLE;
         op_reg        <= PXN_OP_MEM_RD;
         sel_reg       <= 3'h0;
         link_reg      <= 5'h00;
         addr_reg      <= '0;
         wdata_reg     <= '0;
         hub_rdata_reg <= '0;
         hub_ack_reg   <= 1'b0;
      end else begin
         case (hub_state_reg)
            // Operands are stable while the toggle is in flight
            PXN_HUB_IDLE: begin
               if (hub_go) begin
                  op_reg        <= hub_op;
                  sel_reg       <= hub_sel;
                  link_reg      <= hub_link;
                  addr_reg      <= hub_addr;
                  wdata_reg     <= hub_wdata;
                  hub_state_reg <= PXN_HUB_EXEC;
               end
            end
            // Writes happen here, memory read address applied
            PXN_HUB_EXEC: begin
               hub_state_reg <= PXN_HUB_FIN;
            end
            // R09 pointer readback of any link
            PXN_HUB_FIN: begin
               hub_rdata_reg <= '0;
               if (op_reg == PXN_OP_MEM_RD && !sel_reg[2]) begin
                  hub_rdata_reg[`PXN_WORD_W-1:0] <= mdata[hub_rd_link];
               end else if (op_reg == PXN_OP_PTR_RD && link_ok) begin
                  hub_rdata_reg[`PXN_RPTR_LSB +: AW] <= rptr_reg[link_reg];
                  hub_rdata_reg[`PXN_WPTR_LSB +: AW] <= wptr_reg[link_reg];
                  hub_rdata_reg[`PXN_OVF_BIT]        <= ovf_reg[link_reg];
               end
               hub_ack_reg   <= ~hub_ack_reg;
               hub_state_reg <= PXN_HUB_IDLE;
            end
            default: begin
               hub_state_reg <= PXN_HUB_IDLE;
            end
         endcase
      end
   end

   assign hub_rdata = hub_rdata_reg;
   assign hub_ack   = hub_ack_reg;

   // R01 one link per source and destination pair
   for (genvar gl = 0; gl < `PXN_LINKS; gl++) begin : g_link
      localparam int S = gl / `PXN_SLOTS;           // Writing locus
      localparam int K = gl % `PXN_SLOTS;           // Writer's slot
      localparam int D = (K < S) ? K : K + 1;       // Reading locus
      localparam int J = (S < D) ? S : S - 1;       // Reader's slot
      logic                   mwe;                  // Memory write
      logic [AW-1:0]          mwaddr;               // Write address
      logic [`PXN_WORD_W-1:0] mwdata;               // Write word
      logic [AW-1:0]          mraddr;               // Read address
      logic                   ovf_set;              // Dropped word
      wire ptr_hit = hub_ptr_wr && link_reg == 5'(gl);

      // R02 dedicated dual-port buffer
      pxn_link_mem #(.AW(AW), .DW(`PXN_WORD_W)) u_mem (
         .clk     (clk),
         .wr_en   (mwe),
         .wr_addr (mwaddr),
         .wr_data (mwdata),
         .rd_addr (mraddr),
         .rd_data (mdata[gl])
      );

      if (S < `PXN_PORTS) begin : g_port_wr
         logic [AW-1:0] wcur_reg;                   // Writer position
         logic          drop_reg;                   // Packet lost a word
         wire sel    = wr_valid[S] & wr_dest[S*`PXN_SLOTS+K];
         wire full   = AW'(wcur_reg + 1'b1) == rptr_reg[gl];
         wire commit = wr_commit[S] & wr_dest[S*`PXN_SLOTS+K];
         wire abort  = wr_abort[S] & wr_dest[S*`PXN_SLOTS+K];
         // R10 R11 address-free push on packet clock
         assign mwe     = sel & ~full;
         assign mwaddr  = wcur_reg;
         // R04 R13 full word passes with side bits
         assign mwdata  = wr_data[S*`PXN_WORD_W +: `PXN_WORD_W];
         // R05 word to full buffer dropped
         assign ovf_set = sel & full;

         // R14 commit publishes, abort or loss rolls back
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               wcur_reg     <= `PXN_PTR_RST;
               wptr_reg[gl] <= `PXN_PTR_RST;
               drop_reg     <= 1'b0;
            end else if (abort || (commit && (drop_reg || ovf_set))) begin
               // R06 partial packet never visible
               wcur_reg <= wptr_reg[gl];
               drop_reg <= 1'b0;
            end else if (commit) begin
               wcur_reg     <= AW'(wcur_reg + AW'(mwe));
               wptr_reg[gl] <= AW'(wcur_reg + AW'(mwe));
               drop_reg     <= 1'b0;
            end else begin
               wcur_reg <= AW'(wcur_reg + AW'(mwe));
               drop_reg <= drop_reg | ovf_set;
            end
         end
      end else begin : g_hub_wr
         // R08 hub fills its buffers at random
         assign mwe     = hub_mem_wr && sel_reg == 3'(4 + K);
         assign mwaddr  = addr_reg;
         assign mwdata  = wdata_reg[`PXN_WORD_W-1:0];
         assign ovf_set = 1'b0;

         // R09 hub publishes its own fill pointer
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               wptr_reg[gl] <= `PXN_PTR_RST;
            end else if (ptr_hit) begin
               wptr_reg[gl] <= wdata_reg[`PXN_WPTR_LSB +: AW];
            end
         end
      end

      if (D < `PXN_PORTS) begin : g_port_rd
         // R10 address-free pop of the served slot
         wire pop = rd_pop[D] & valid_reg[D] & lock_reg[D] &
                    slot_reg[D] == 2'(J);
         assign rptr_nx[gl] = AW'(rptr_reg[gl] + AW'(pop));
         assign mraddr      = rptr_nx[gl];
      end else begin : g_hub_rd
         // R09 hub moves only the read pointer it owns
         assign rptr_nx[gl] = ptr_hit ? wdata_reg[`PXN_RPTR_LSB +: AW]
                                      : rptr_reg[gl];
         // R08 hub reads its buffers at random
         assign mraddr      = addr_reg;
      end

      // Read pointer and sticky overflow, set wins over clear
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            rptr_reg[gl] <= `PXN_PTR_RST;
            ovf_reg[gl]  <= 1'b0;
         end else begin
            rptr_reg[gl] <= rptr_nx[gl];
            // R05 overflow flag raised
            if (ovf_set) begin
               ovf_reg[gl] <= 1'b1;
            end else if (ptr_hit && wdata_reg[`PXN_OVF_BIT]) begin
               ovf_reg[gl] <= 1'b0;
            end
         end
      end

      assign overflow[gl] = ovf_reg[gl];
   end

   // R03 four receive slots per port reader
   for (genvar gd = 0; gd < `PXN_PORTS; gd++) begin : g_rd
      logic [3:0]             ne;                   // Slot has data
      logic [`PXN_WORD_W-1:0] pdata [`PXN_SLOTS];   // Slot read words
      logic [2:0]             pick;                 // Found and slot
      logic                   lock_next;            // Lock next
      logic [1:0]             slot_next;            // Slot next

      for (genvar gj = 0; gj < `PXN_SLOTS; gj++) begin : g_slot
         localparam int S = (gj < gd) ? gj : gj + 1;
         localparam int L = S * `PXN_SLOTS + ((gd < S) ? gd : gd - 1);
         assign ne[gj]    = wptr_reg[L] != rptr_nx[L];
         assign pdata[gj] = mdata[L];
      end

      // R07 round robin over non-empty slots
      assign pick      = rr_pick(ne, slot_reg[gd]);
      assign lock_next = lock_reg[gd] ? ~rd_done[gd] : pick[2];
      assign slot_next = (!lock_reg[gd] && pick[2]) ? pick[1:0]
                                                    : slot_reg[gd];

      // Arbitration state and word-present flag
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            lock_reg[gd]  <= 1'b0;
            slot_reg[gd]  <= 2'h3;
            valid_reg[gd] <= 1'b0;
         end else begin
            lock_reg[gd]  <= lock_next;
            slot_reg[gd]  <= slot_next;
            valid_reg[gd] <= lock_next & ne[slot_next];
         end
      end

      assign rd_valid[gd]                          = valid_reg[gd];
      assign rd_slot[gd*2 +: 2]                    = slot_reg[gd];
      assign rd_data[gd*`PXN_WORD_W +: `PXN_WORD_W] = pdata[slot_reg[gd]];
   end

endmodule

// ==== dv/pxn_exchange_assertions.sv ====
// Checker for the packet exchange: port read holding and hub handshake.
// Assumes binding to pxn_exchange; one clock, reset_n active low.
`timescale 1ns/1ps
module pxn_exchange_checker
   import pxn_pkg::*;
(
   input wire logic          clk,
   input wire logic          reset_n,
   input wire logic [3:0]    wr_valid,
   input wire logic [3:0]    rd_pop,
   input wire logic [3:0]    rd_done,
   input wire logic [3:0]    rd_valid,
   input wire logic [143:0]  rd_data,
   input wire logic [7:0]    rd_slot,
   input wire logic [19:0]   overflow,
   input wire logic          hub_req,
   input wire pxn_op_t       hub_op,
   input wire logic [63:0]   hub_wdata,
   input wire logic [63:0]   hub_rdata,
   input wire logic          hub_ack
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Hub request seen, answer expected within the sync window
   sequence hub_ask_s;
      $changed(hub_req);
   endsequence
   sequence hub_answer_s;
      ##[3:7] $changed(hub_ack);
   endsequence

   ack_pace_a: assert property (hub_ask_s |-> hub_answer_s)
      else $error("hub ack missing after request");
   ack_match_a: assert property ($changed(hub_ack)
      |-> hub_ack == hub_req)
      else $error("hub ack toggled without request");
   rdata_hold_a: assert property (!$changed(hub_ack)
      |-> $stable(hub_rdata))
      else $error("hub read data moved between answers");
   ovf_cause_a: assert property (|(overflow & ~$past(overflow))
      |-> $past(|wr_valid))
      else $error("overflow raised without a write");
   ovf_clear_a: assert property (|($past(overflow) & ~overflow)
      |-> hub_op == PXN_OP_PTR_WR && hub_wdata[32])
      else $error("overflow dropped without clear request");

   // Per reader port: word holds until popped, slot fixed while locked
   // Slot and valid rise on one edge, so stability is checked next cycle
   for (genvar d = 0; d < 4; d++) begin : g_rd
      rd_hold_a: assert property (rd_valid[d] && !rd_pop[d]
         && !rd_done[d] |=> rd_valid[d] && $stable(rd_data[d*36+:36]))
         else $error("read word not held");
      done_free_a: assert property (rd_done[d] |=> !rd_valid[d])
         else $error("reader still valid after done");
      slot_lock_a: assert property (rd_valid[d]
         |=> $stable(rd_slot[d*2+:2]))
         else $error("slot moved while locked");
   end
endmodule

bind pxn_exchange pxn_exchange_checker chk (
   .clk(clk), .reset_n(reset_n), .wr_valid(wr_valid), .rd_pop(rd_pop),
   .rd_done(rd_done), .rd_valid(rd_valid), .rd_data(rd_data),
   .rd_slot(rd_slot), .overflow(overflow), .hub_req(hub_req),
   .hub_op(hub_op), .hub_wdata(hub_wdata), .hub_rdata(hub_rdata),
   .hub_ack(hub_ack));

// ==== dv/pxn_hub_model.sv ====
// Hub side model: issues toggle requests and waits for the toggle answer.
// Assumes the caller waits for each request before the next one.
`timescale 1ns/1ps
module pxn_hub_model
   import pxn_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         hub_ack,
   input  wire logic [63:0]  hub_rdata,
   output logic              hub_req,
   output pxn_op_t           hub_op,
   output logic [2:0]        hub_sel,
   output logic [4:0]        hub_link,
   output logic [8:0]        hub_addr,
   output logic [63:0]       hub_wdata,
   output logic              hub_err
);
   // Idle levels; request line at its reset level
   initial begin
      hub_req = 1'b0;
      hub_op = PXN_OP_MEM_RD;
      hub_sel = '0;
      hub_link = '0;
      hub_addr = '0;
      hub_wdata = '0;
      hub_err = 1'b0;
   end

   // One request; gap idles first so slow hubs are exercised too
   task req(input pxn_op_t op, input int sel, input int lnk, input int adr,
            input logic [63:0] wd, input int gap, output logic [63:0] rd);
      int n;
      repeat (gap) @(posedge clk);
      @(posedge clk);
      hub_op <= op;
      hub_sel <= 3'(sel);
      hub_link <= 5'(lnk);
      hub_addr <= 9'(adr);
      hub_wdata <= wd;
      hub_req <= ~hub_req;
      n = 0;
      @(posedge clk);
      while (hub_ack !== hub_req && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
         hub_err = 1'b1;
      rd = hub_rdata;
   endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the exchange: port traffic, hub requests.
// Assumes pxn_hub_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb
   import pxn_pkg::*;
;
   typedef struct {int p; int k; int d; logic [1:0] s;
                   logic [35:0] w;} pxn_row_t;
   logic          clk = 1'b0;
   logic          reset_n = 1'b0;
   logic [3:0]    wr_valid = '0, wr_commit = '0, wr_abort = '0;
   logic [3:0]    rd_pop = '0, rd_done = '0, rd_valid;
   logic [143:0]  wr_data = '0, rd_data;
   logic [15:0]   wr_dest = '0;
   logic [7:0]    rd_slot;
   logic [19:0]   overflow;
   logic          hub_req, hub_ack, hub_err;
   pxn_op_t       hub_op;
   logic [2:0]    hub_sel;
   logic [4:0]    hub_link;
   logic [8:0]    hub_addr;
   logic [63:0]   hub_wdata, hub_rdata, hr;
   int            fail_count = 0, checks_done = 0, i, n;
   // Source, dest bit, reader, slot, word with side bits
   pxn_row_t rows[5] = '{'{0,0,1,2'h0,36'h5_0000_0a01},
      '{1,0,0,2'h0,36'h3_0000_1b02}, '{2,2,3,2'h2,36'hc_0000_2c03},
      '{3,1,1,2'h2,36'h0_0000_3d04}, '{1,2,3,2'h1,36'hf_0000_4e05}};

   always #12.5 clk = ~clk;

   pxn_exchange uut (.clk(clk), .reset_n(reset_n), .wr_valid(wr_valid),
      .wr_data(wr_data), .wr_dest(wr_dest), .wr_commit(wr_commit),
      .wr_abort(wr_abort), .rd_pop(rd_pop), .rd_done(rd_done),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_slot(rd_slot),
      .overflow(overflow), .hub_req(hub_req), .hub_op(hub_op),
      .hub_sel(hub_sel), .hub_link(hub_link), .hub_addr(hub_addr),
      .hub_wdata(hub_wdata), .hub_rdata(hub_rdata), .hub_ack(hub_ack));
   pxn_hub_model hub (.clk(clk), .hub_ack(hub_ack), .hub_rdata(hub_rdata),
      .hub_req(hub_req), .hub_op(hub_op), .hub_sel(hub_sel),
      .hub_link(hub_link), .hub_addr(hub_addr), .hub_wdata(hub_wdata),
      .hub_err(hub_err));

   // Compare and count
   task check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Hub answer that never came counts as a mismatch and ends the run
   always @(posedge hub_err) begin
      fail_count++;
      wrap_up();
   end

   // Verdict and end of run
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One-word push; released data lines show inverted garbage
   task push(input int p, input logic [3:0] dst, input logic [35:0] w,
             input logic cm, input logic ab);
      @(posedge clk);
      wr_valid[p] <= 1'b1;
      wr_dest[p*4+:4] <= dst;
      wr_data[p*36+:36] <= w;
      wr_commit[p] <= cm;
      wr_abort[p] <= ab;
      @(posedge clk);
      wr_valid <= '0;
      wr_commit <= '0;
      wr_abort <= '0;
      wr_data <= ~wr_data;
   endtask

   // Wait for a word at reader d, check it, pop it and finish the packet
   task pull(input int d, input logic [35:0] w, input logic [1:0] s);
      n = 0;
      while (rd_valid[d] !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (n >= 60) begin
         fail_count++;
         wrap_up();
      end
      check(rd_data[d*36+:36], w);
      check(rd_slot[d*2+:2], s);
      @(posedge clk);
      rd_pop[d] <= 1'b1;
      @(posedge clk);
      rd_pop <= '0;
      rd_done[d] <= 1'b1;
      @(posedge clk);
      rd_done <= '0;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({rd_valid, rd_slot, overflow, hub_ack}, {4'h0, 8'hff, 20'h0, 1'b0});
      check(hub_rdata, 64'h0);
      @(posedge clk);
      reset_n <= 1'b1;
      $display("reset test done");
      // Ordinary routes, one word committed with its own write
      for (i = 0; i < 5; i++) begin
         push(rows[i].p, 4'h1 << rows[i].k, rows[i].w, 1'b1, 1'b0);
         pull(rows[i].d, rows[i].w, rows[i].s);
      end
      $display("route table done");
      push(0, 4'h1, 36'h1_0000_0bad, 1'b0, 1'b1);
      repeat (10) @(negedge clk);
      check(rd_valid[1], 1'b0);
      push(0, 4'h1, 36'h2_0000_0600, 1'b1, 1'b0);
      pull(1, 36'h2_0000_0600, 2'h0);
      $display("abort test done");
      // Three writers commit together; reader continues after slot 0
      @(posedge clk);
      wr_valid <= 4'b1101;
      wr_commit <= 4'b1101;
      wr_dest <= 16'h2201;
      wr_data <= {36'h3_0000_0003, 36'h2_0000_0002, 36'h0, 36'h1_0000_0001};
      @(posedge clk);
      wr_valid <= '0;
      wr_commit <= '0;
      pull(1, 36'h2_0000_0002, 2'h1);
      pull(1, 36'h3_0000_0003, 2'h2);
      pull(1, 36'h1_0000_0001, 2'h0);
      $display("round robin done");
      // Hub reads its buffer, fills one for port 0, pointer rights
      push(0, 4'h8, 36'h9_0000_00aa, 1'b1, 1'b0);
      hub.req(PXN_OP_PTR_RD, 0, 3, 0, '0, 0, hr);
      check(hr, 64'h1_0000);
      hub.req(PXN_OP_MEM_RD, 0, 0, 0, '0, 2, hr);
      check(hr, 64'h9_0000_00aa);
      hub.req(PXN_OP_PTR_WR, 0, 3, 0, 64'h1_0001, 0, hr);
      hub.req(PXN_OP_PTR_RD, 0, 3, 0, '0, 0, hr);
      check(hr, 64'h1_0001);
      hub.req(PXN_OP_MEM_WR, 4, 0, 0, 64'h6_0000_00bb, 0, hr);
      hub.req(PXN_OP_PTR_WR, 0, 16, 0, 64'h1_0000, 3, hr);
      pull(0, 36'h6_0000_00bb, 2'h3);
      hub.req(PXN_OP_PTR_WR, 0, 0, 0, 64'h5_0005, 0, hr);
      hub.req(PXN_OP_PTR_RD, 0, 0, 0, '0, 0, hr);
      check(hr, 64'h3_0003);
      hub.req(PXN_OP_PTR_RD, 0, 20, 0, '0, 0, hr);
      check(hr, 64'h0);
      hub.req(PXN_OP_MEM_RD, 5, 0, 0, '0, 0, hr);
      check(hr, 64'h0);
      $display("hub test done");
      // Fill link 2 past its 511 words; commit on the dropped word
      for (i = 0; i < 512; i++) begin
         @(posedge clk);
         wr_valid[0] <= 1'b1;
         wr_dest[3:0] <= 4'h4;
         wr_data[35:0] <= 36'(i);
         wr_commit[0] <= (i == 511);
      end
      @(posedge clk);
      wr_valid <= '0;
      wr_commit <= '0;
      repeat (10) @(negedge clk);
      check(overflow, 20'h00004);
      check(rd_valid[3], 1'b0);
      hub.req(PXN_OP_PTR_WR, 0, 2, 0, 64'h1_0000_0000, 0, hr);
      hub.req(PXN_OP_PTR_RD, 0, 2, 0, '0, 0, hr);
      check(hr, 64'h0);
      push(0, 4'h4, 36'h7_0000_0777, 1'b1, 1'b0);
      pull(3, 36'h7_0000_0777, 2'h0);
      check(hub_err, 1'b0);
      $display("overflow test done");
      wrap_up();
   end
endmodule
